// [hw/can_transceiver_fault_control.sv]
// Control logic of a high-speed CAN transceiver: mode selection, bus
// drive and bias enables, receive output, dominant timeout, fault gating.
// Assumes every pin input is asynchronous to clk; analog driver and
// receiver sit outside and act on the drive struct.
//
// Overview of operation
// R1 - low means dominant, high means recessive
// R2 - timeout supervision only in normal mode
// R3 - transmit falling edge starts timeout timer
// R4 - timeout without rising edge disables driver
// R5 - recessive transmit re-enables driver, clears fault
// R6 - receiver keeps mirroring bus during timeout
// R7 - controller keeps dominant runs below timeout
// R8 - overtemperature disables driver and transmit path
// R9 - overtemperature keeps mid bias and receiver
// R10 - either supply undervoltage releases the bus
// R11 - core low, standby high gives standby
// R12 - core low, standby low gives protected
// R13 - receive output undriven without I/O supply
// R14 - standby biases both lines weakly to ground
// R15 - standby input may be tied low
// R16 - standby high selects standby, low normal
// R17 - normal resumes after mode delay expires
// R18 - armed monitor pulls receive low per dominant
// R19 - synchronised transmit input, timeout in cycles
// R20 - both supplies good, standby low: normal drive and mirror
`timescale 1ns/10ps
`default_nettype none

module can_transceiver_fault_control
  import can_xcvr_pkg::*;
#(
  parameter int unsigned DOM_TMO_CYCLES = DOM_TMO_DEF,
  parameter int unsigned MODE_CYCLES    = MODE_CYCLES_DEF,
  parameter int unsigned WAKE_TMO_CYCLES = WAKE_TMO_DEF
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire pins_s      pins,
  output bus_drive_s      drive,
  output logic            rxd,
  output logic            rxd_oe,
  output mode_e           mode,
  output logic            dominant_timeout,
  output logic            overtemp_active,
  output logic            evt_valid,
  input  wire logic       evt_ready,
  output evt_s            evt_data
);

  // ==========================================================================
  // reset release
  logic [1:0] rst_pipe_reg;
  logic       rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe_reg[1];

  // ==========================================================================
  // state
  localparam int unsigned DW = $clog2(DOM_TMO_CYCLES + 1);
  localparam int unsigned MW = $clog2(MODE_CYCLES + 1);
  localparam logic [DW-1:0] TMO_LAST  = DW'(DOM_TMO_CYCLES - 1);
  localparam logic [MW-1:0] MODE_LAST = MW'(MODE_CYCLES - 1);

  typedef struct packed {
    pins_s            s1;
    pins_s            s2;
    logic             txd_prev;
    mode_e            mode;
    logic [MW-1:0]    mode_cnt;
    logic [DW-1:0]    tmo_cnt;
    logic             tmo_flag;
    logic             ot;
    bus_drive_s       drv;
    logic             rxd;
    logic             rxd_oe;
    logic [EVT_N-1:0] pend;
  } ctl_s;

  ctl_s             r_reg;
  ctl_s             r_next;
  logic             wake_rxd;
  logic             txd_s;
  logic             bus_s;
  logic             tx_fall;
  logic             normal;
  mode_e            target;
  logic [EVT_N-1:0] evt_set;
  logic [EVT_N-1:0] evt_clr;
  logic [2:0]       evt_sel;
  logic             fifo_ready;
  evt_s             push_data;

  // ==========================================================================
  // standby wake monitor and event queue
  wake_monitor #(
    .FILTER_CYCLES  (WAKE_FILTER_CYC),
    .TIMEOUT_CYCLES (WAKE_TMO_CYCLES)
  ) u_wake (
    .clk          (clk),
    .rst_n        (rst_n),
    .enable       (r_reg.mode == MODE_STANDBY),
    .bus_dominant (r_reg.s2.bus_dominant),
    .rxd_wake     (wake_rxd)
  );

  // events wait in pend while the queue is full; a repeat of a still pending event merges into its flag
  evt_fifo #(
    .WIDTH (EVT_W),
    .DEPTH (EVT_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (|r_reg.pend),
    .in_ready  (fifo_ready),
    .in_data   (push_data),
    .out_valid (evt_valid),
    .out_ready (evt_ready),
    .out_data  (evt_data)
  );

  // ==========================================================================
  // next state
  always_comb begin
    r_next  = r_reg;
    evt_set = '0;
    evt_clr = '0;
    evt_sel = 3'h0;
    // first stage feeds only the second
    r_next.s1 = pins;
    r_next.s2 = r_reg.s1; // R19
    txd_s     = r_reg.s2.txd;
    bus_s     = r_reg.s2.bus_dominant;
    r_next.txd_prev = txd_s;
    tx_fall   = r_reg.txd_prev & ~txd_s;

    // either supply low releases the bus; core low splits on standby input
    if (r_reg.s2.io_supply_low) begin
      target = MODE_IO_LOST; // R10
    end else if (r_reg.s2.core_supply_low) begin
      target = r_reg.s2.standby_sel ? MODE_STANDBY : MODE_PROTECTED; // R11 R12
    end else begin
      target = r_reg.s2.standby_sel ? MODE_STANDBY : MODE_NORMAL; // R16
    end

    // leaving normal is immediate, entering it waits the mode delay
    if (target != MODE_NORMAL) begin
      r_next.mode     = target;
      r_next.mode_cnt = '0;
    end else if (r_reg.mode == MODE_NORMAL) begin
      r_next.mode_cnt = '0;
    end else if (r_reg.mode_cnt == MODE_LAST) begin
      r_next.mode     = MODE_NORMAL; // R17
      r_next.mode_cnt = '0;
    end else begin
      r_next.mode_cnt = r_reg.mode_cnt + 1'b1;
    end
    normal = (r_next.mode == MODE_NORMAL);

    // dominant timeout
    if (!normal) begin
      r_next.tmo_cnt  = '0; // R2
      r_next.tmo_flag = 1'b0;
    end else if (txd_s) begin
      r_next.tmo_cnt  = '0; // R5
      r_next.tmo_flag = 1'b0;
    end else if (tx_fall) begin
      r_next.tmo_cnt  = {{(DW-1){1'b0}}, 1'b1}; // R3
    end else if (r_reg.tmo_cnt != '0 && !r_reg.tmo_flag) begin
      r_next.tmo_cnt = r_reg.tmo_cnt + 1'b1;
      if (r_reg.tmo_cnt == TMO_LAST) begin
        r_next.tmo_flag = 1'b1; // R4
      end
    end

    // overtemperature has hysteresis upstream, follow it directly
    r_next.ot = r_reg.s2.overtemp_shutdown;

    // drive: low transmit is dominant; faults gate the driver only
    r_next.drv.drv_en       = normal & ~r_next.ot & ~r_next.tmo_flag; // R4 R8
    r_next.drv.drv_dominant = r_next.drv.drv_en & ~txd_s; // R1 R20
    r_next.drv.bias_mid     = normal; // R9
    r_next.drv.bias_gnd     = (r_next.mode == MODE_STANDBY); // R14

    case (r_next.mode)
      MODE_NORMAL: begin
        r_next.rxd    = ~bus_s; // R1 R6 R20
        r_next.rxd_oe = 1'b1;
      end
      MODE_STANDBY: begin
        r_next.rxd    = wake_rxd; // R11
        r_next.rxd_oe = 1'b1;
      end
      MODE_PROTECTED: begin
        r_next.rxd    = RXD_IDLE; // R12
        r_next.rxd_oe = 1'b1;
      end
      default: begin
        r_next.rxd    = RXD_IDLE;
        r_next.rxd_oe = 1'b0; // R13
      end
    endcase

    // event log
    evt_set[EVT_TMO_SET] = r_next.tmo_flag & ~r_reg.tmo_flag;
    evt_set[EVT_TMO_CLR] = ~r_next.tmo_flag & r_reg.tmo_flag;
    evt_set[EVT_OT_SET]  = r_next.ot & ~r_reg.ot;
    evt_set[EVT_OT_CLR]  = ~r_next.ot & r_reg.ot;
    evt_set[EVT_MODE]    = (r_next.mode != r_reg.mode);
    for (int i = EVT_N - 1; i >= 0; i--) begin
      if (r_reg.pend[i]) begin
        evt_sel = 3'(i);
      end
    end
    if (fifo_ready && (|r_reg.pend)) begin
      evt_clr[evt_sel] = 1'b1;
    end
    // a new event wins over the clear of the same flag
    r_next.pend = (r_reg.pend & ~evt_clr) | evt_set;
  end

  assign push_data.code = evt_code_e'(evt_sel);
  assign push_data.mode = r_reg.mode;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg          <= '0;
      r_reg.s1.txd   <= TXD_IDLE;
      r_reg.s2.txd   <= TXD_IDLE;
      r_reg.txd_prev <= TXD_IDLE;
      r_reg.mode     <= RST_MODE;
      r_reg.rxd      <= RXD_IDLE;
      r_reg.rxd_oe   <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign drive            = r_reg.drv;
  assign rxd              = r_reg.rxd;
  assign rxd_oe           = r_reg.rxd_oe;
  assign mode             = r_reg.mode;
  assign dominant_timeout = r_reg.tmo_flag;
  assign overtemp_active  = r_reg.ot;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_tmo_mode_only: assert property ( // R2
    (r_reg.mode != MODE_NORMAL) |-> (!r_reg.tmo_flag && r_reg.tmo_cnt == '0))
    else $error("timeout active outside normal mode");

  a_tmo_start: assert property ( // R3
    (r_reg.mode == MODE_NORMAL && r_reg.txd_prev && !r_reg.s2.txd)
      ##1 (r_reg.mode == MODE_NORMAL) |-> (r_reg.tmo_cnt == 1))
    else $error("timer not started on falling edge");

  a_tmo_fire: assert property ( // R4
    $rose(r_reg.tmo_flag) |-> ($past(r_reg.tmo_cnt) == TMO_LAST && !r_reg.drv.drv_en))
    else $error("timeout fired at wrong count");

  a_tmo_release: assert property ( // R5
    (r_reg.tmo_flag && r_reg.s2.txd) |=> !r_reg.tmo_flag)
    else $error("timeout not cleared by recessive input");

  a_rx_mirror: assert property ( // R6
    (r_reg.mode == MODE_NORMAL) |-> (r_reg.rxd == !$past(r_reg.s2.bus_dominant)))
    else $error("receive output not mirroring bus");

  a_tx_map: assert property ( // R1
    r_reg.drv.drv_en |-> (r_reg.drv.drv_dominant == !$past(r_reg.s2.txd)))
    else $error("driver not following transmit input");

  a_ot_gate: assert property ( // R8
    r_reg.ot |-> (!r_reg.drv.drv_en && !r_reg.drv.drv_dominant))
    else $error("driver active during overtemperature");

  a_ot_bias: assert property ( // R9
    (r_reg.ot && r_reg.mode == MODE_NORMAL) |-> (r_reg.drv.bias_mid && r_reg.rxd_oe))
    else $error("bias or receiver lost during overtemperature");

  a_prot_state: assert property ( // R12
    (r_reg.mode == MODE_PROTECTED) |->
      (r_reg.rxd && r_reg.rxd_oe && r_reg.drv == '0))
    else $error("protected mode outputs wrong");

  a_io_float: assert property ( // R13
    (r_reg.mode == MODE_IO_LOST) |-> (!r_reg.rxd_oe && r_reg.drv == '0))
    else $error("outputs driven without io supply");

  a_standby_bias: assert property ( // R14
    (r_reg.mode == MODE_STANDBY) |->
      (r_reg.drv.bias_gnd && !r_reg.drv.bias_mid && !r_reg.drv.drv_en))
    else $error("standby bias wrong");

  a_normal_delay: assert property ( // R17
    $rose(r_reg.mode == MODE_NORMAL) |-> ($past(r_reg.mode_cnt) == MODE_LAST))
    else $error("normal mode entered before mode delay");

  a_wake_rxd: assert property ( // R18
    (r_reg.mode == MODE_STANDBY) |-> (r_reg.rxd == $past(wake_rxd)))
    else $error("standby receive output not from wake monitor");

  c_tmo_fire:  cover property ($rose(r_reg.tmo_flag));
  c_ot_normal: cover property (r_reg.ot && r_reg.mode == MODE_NORMAL);
  c_wake_low:  cover property (r_reg.mode == MODE_STANDBY && !r_reg.rxd);
  c_fifo_full: cover property (|r_reg.pend && !fifo_ready);

endmodule

`default_nettype wire

// [hw/can_xcvr_pkg.sv]
// Shared constants, mode and event codes, and carrier structs for the
// transceiver fault control block.
// Assumes a single 100 MHz timing clock; all times are given in ns.
package can_xcvr_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  // dominant timeout, typical 1.2 ms
  localparam int unsigned DOM_TMO_NS      = 1200000;
  localparam int unsigned DOM_TMO_DEF     = DOM_TMO_NS / CLK_PERIOD_NS;
  // mode change time, at most 45 us, so rounded down
  localparam int unsigned MODE_TIME_NS    = 45000;
  localparam int unsigned MODE_CYCLES_DEF = MODE_TIME_NS / CLK_PERIOD_NS;
  // wake filter, a least time, so rounded up
  localparam int unsigned WAKE_FILTER_NS  = 1000;
  localparam int unsigned WAKE_FILTER_CYC =
    (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // wake timeout, kept at its lower limit
  localparam int unsigned WAKE_TMO_NS     = 800000;
  localparam int unsigned WAKE_TMO_DEF    = WAKE_TMO_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // modes and events
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_STANDBY,
    MODE_PROTECTED,
    MODE_IO_LOST
  } mode_e;

  typedef enum logic [2:0] {
    EVT_TMO_SET,
    EVT_TMO_CLR,
    EVT_OT_SET,
    EVT_OT_CLR,
    EVT_MODE
  } evt_code_e;

  localparam int unsigned EVT_N      = 5;
  localparam int unsigned EVT_DEPTH  = 16;

  // ==========================================================================
  // reset values
  localparam mode_e      RST_MODE  = MODE_PROTECTED;
  localparam logic       TXD_IDLE  = 1'b1;
  localparam logic       RXD_IDLE  = 1'b1;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic txd;
    logic standby_sel;
    logic bus_dominant;
    logic overtemp_shutdown;
    logic core_supply_low;
    logic io_supply_low;
  } pins_s;

  typedef struct packed {
    logic drv_en;
    logic drv_dominant;
    logic bias_mid;
    logic bias_gnd;
  } bus_drive_s;

  typedef struct packed {
    evt_code_e code;
    mode_e     mode;
  } evt_s;

  localparam int unsigned EVT_W = $bits(evt_s);

endpackage

// [hw/evt_fifo.sv]
// Event FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; pointers wrap naturally.
`timescale 1ns/10ps
`default_nettype none

module evt_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_V = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } fifo_s;

  fifo_s r_reg;
  fifo_s r_next;
  logic  push;
  logic  pop;

  assign in_ready  = (r_reg.cnt != FULL_V);
  assign out_valid = (r_reg.cnt != '0);
  assign out_data  = r_reg.mem[r_reg.rp];

  always_comb begin
    r_next = r_reg;
    push   = in_valid & in_ready;
    pop    = out_valid & out_ready;
    if (push) begin
      r_next.mem[r_reg.wp] = in_data;
      r_next.wp            = r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
    case ({push, pop})
      2'b10:   r_next.cnt = r_reg.cnt + 1'b1;
      2'b01:   r_next.cnt = r_reg.cnt - 1'b1;
      default: r_next.cnt = r_reg.cnt;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule

`default_nettype wire

// [hw/wake_monitor.sv]
// Standby bus monitor: filtered dominant / recessive / dominant pattern,
// with a low on its output for the closing dominant and each one after it.
// Assumes bus_dominant is already synchronised to clk.
`timescale 1ns/10ps
`default_nettype none

module wake_monitor
  import can_xcvr_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES  = WAKE_FILTER_CYC,
  parameter int unsigned TIMEOUT_CYCLES = WAKE_TMO_DEF
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic bus_dominant,
  output logic      rxd_wake
);

  localparam int unsigned FW = $clog2(FILTER_CYCLES + 1);
  localparam int unsigned TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [FW-1:0] FILT_V = FW'(FILTER_CYCLES);
  localparam logic [TW-1:0] TMO_V  = TW'(TIMEOUT_CYCLES);

  typedef enum {W_IDLE, W_DOM1, W_REC, W_ARMED} wake_e;

  typedef struct packed {
    wake_e         state;
    logic          last;
    logic [FW-1:0] run;
    logic [TW-1:0] tmo;
    logic          rxd;
  } wake_s;

  wake_s r_reg;
  wake_s r_next;
  logic  qual;
  logic  dom_q;
  logic  rec_q;

  assign rxd_wake = r_reg.rxd;

  always_comb begin
    r_next = r_reg;
    // a state counts as filtered once held longer than the filter time
    qual   = (r_reg.run == FILT_V);
    dom_q  = qual & r_reg.last;
    rec_q  = qual & ~r_reg.last;
    if (r_reg.last != bus_dominant) begin
      r_next.last = bus_dominant;
      r_next.run  = '0;
    end else if (!qual) begin
      r_next.run = r_reg.run + 1'b1;
    end
    // other traffic between the phases does not reset the monitor
    case (r_reg.state)
      W_IDLE: begin
        r_next.tmo = '0;
        if (dom_q) begin
          r_next.state = W_DOM1;
        end
      end
      W_DOM1: begin
        if (rec_q) begin
          r_next.state = W_REC;
        end
      end
      W_REC: begin
        if (dom_q) begin
          r_next.state = W_ARMED;
        end
      end
      W_ARMED: begin
        r_next.tmo = '0;
      end
      default: begin
        r_next.state = W_IDLE;
      end
    endcase
    if (r_reg.state == W_DOM1 || r_reg.state == W_REC) begin
      if (r_reg.tmo == TMO_V) begin
        r_next.state = W_IDLE;
      end else begin
        r_next.tmo = r_reg.tmo + 1'b1;
      end
    end
    if (!enable) begin
      r_next.state = W_IDLE;
      r_next.tmo   = '0;
    end
    r_next.rxd = ~((r_next.state == W_ARMED) & dom_q); // R18
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg       <= '0;
      r_reg.state <= W_IDLE;
      r_reg.rxd   <= RXD_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule

`default_nettype wire

// [testbench/can_bus_model.sv]
// Far side of the transceiver: the shared bus seen by the receiver.
// Assumes the drive struct of the block and one other node on the wire.
`timescale 1ns/10ps
`default_nettype none

module can_bus_model
  import can_xcvr_pkg::*;
(
  input  wire bus_drive_s drive,
  input  wire logic       other_dom,
  output logic            bus_dominant
);
  // ==========================================================================
  // wired bus
  // dominant from any node overwrites recessive
  assign bus_dominant = (drive.drv_en & drive.drv_dominant) | other_dom;
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the transceiver fault control block.
// Assumes the package, design modules and can_bus_model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb
  import can_xcvr_pkg::*;
;
  // ==========================================================================
  // signals
  localparam int unsigned TMO   = 50;
  localparam int unsigned MDC   = 20;
  localparam int unsigned LIMIT = 5000;

  logic       clk;
  logic       nrst;
  logic       txd;
  logic       standby;
  logic       hot;
  logic       core_low;
  logic       io_low;
  logic       other_dom;
  logic       bus_dom;
  logic       evt_ready;
  pins_s      pins;
  bus_drive_s drive;
  logic       rxd;
  logic       rxd_oe;
  mode_e      mode;
  logic       tmo_seen;
  logic       hot_seen;
  logic       evt_valid;
  evt_s       evt_data;
  int         errors;
  int         checks;
  int         cyc;
  evt_code_e  codes[$];

  assign pins = '{txd: txd, standby_sel: standby, bus_dominant: bus_dom,
                  overtemp_shutdown: hot, core_supply_low: core_low, io_supply_low: io_low};

  can_transceiver_fault_control #(
    .DOM_TMO_CYCLES (TMO),
    .MODE_CYCLES    (MDC),
    .WAKE_TMO_CYCLES(2000)
  ) dut (
    .clk             (clk),
    .nrst            (nrst),
    .pins            (pins),
    .drive           (drive),
    .rxd             (rxd),
    .rxd_oe          (rxd_oe),
    .mode            (mode),
    .dominant_timeout(tmo_seen),
    .overtemp_active (hot_seen),
    .evt_valid       (evt_valid),
    .evt_ready       (evt_ready),
    .evt_data        (evt_data)
  );

  can_bus_model bus_far (
    .drive       (drive),
    .other_dom   (other_dom),
    .bus_dominant(bus_dom)
  );

  // ==========================================================================
  // tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic put(input logic t, input logic s, input logic h, input logic c, input logic i);
    @(posedge clk);
    txd      <= t;
    standby  <= s;
    hot      <= h;
    core_low <= c;
    io_low   <= i;
  endtask

  task automatic bus(input logic d);
    @(posedge clk);
    other_dom <= d;
  endtask

  task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
    checks++;
    if (exp !== got) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      print_verdict();
    end
  end

  // ==========================================================================
  // sequence
  initial begin
    nrst      = 1'b0;
    txd       = 1'b1;
    standby   = 1'b0;
    hot       = 1'b0;
    core_low  = 1'b0;
    io_low    = 1'b0;
    other_dom = 1'b0;
    evt_ready = 1'b1;
    errors    = 0;
    checks    = 0;
    cyc       = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    step(1);
    chk("mode_rst", 5'(MODE_PROTECTED), 5'(mode));
    chk("drive_rst", 5'h00, 5'(drive));
    step(14);
    chk("mode_hold", 5'h00, 5'(mode == MODE_NORMAL));
    step(20);
    chk("mode_norm", 5'(MODE_NORMAL), 5'(mode));
    chk("drive_norm", 5'h0A, 5'(drive));
    chk("rxd_norm", 5'h01, 5'(rxd));
    // eleven-bit dominant run, shorter than the timeout
    put(0, 0, 0, 0, 0);
    step(8);
    chk("drive_dom", 5'h0E, 5'(drive));
    chk("rxd_dom", 5'h00, 5'(rxd));
    step(30);
    put(1, 0, 0, 0, 0);
    step(5);
    chk("tmo_short", 5'h00, 5'(tmo_seen));
    put(0, 0, 0, 0, 0);
    step(TMO - 2);
    chk("tmo_early", 5'h00, 5'(tmo_seen));
    step(6);
    chk("tmo_set", 5'h01, 5'(tmo_seen));
    chk("drive_tmo", 5'h02, 5'(drive));
    bus(1'b1);
    step(6);
    chk("rxd_tmo", 5'h00, 5'(rxd));
    bus(1'b0);
    put(1, 0, 0, 0, 0);
    step(5);
    chk("tmo_clr", 5'h00, 5'(tmo_seen));
    chk("drive_tmo_clr", 5'h0A, 5'(drive));
    // transmit path blocked while hot
    put(0, 0, 1, 0, 0);
    step(6);
    chk("hot_flag", 5'h01, 5'(hot_seen));
    chk("drive_hot", 5'h02, 5'(drive));
    bus(1'b1);
    step(6);
    chk("rxd_hot", 5'h00, 5'(rxd));
    bus(1'b0);
    put(1, 0, 0, 0, 0);
    step(6);
    chk("drive_cool", 5'h0A, 5'(drive));
    // fill the event queue with the consumer stalled, then drain it
    @(posedge clk);
    evt_ready <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      put(1, 0, 1, 0, 0);
      step(8);
      put(1, 0, 0, 0, 0);
      step(8);
    end
    chk("evt_held", 5'h01, 5'(evt_valid));
    @(posedge clk);
    evt_ready <= 1'b1;
    repeat (30) begin
      @(negedge clk);
      if (evt_valid === 1'b1) begin
        codes.push_back(evt_data.code);
        chk("evt_mode", 5'(MODE_NORMAL), 5'(evt_data.mode));
      end
    end
    chk("evt_count", 5'h12, 5'(codes.size()));
    foreach (codes[k]) chk("evt_code", 5'(k[0] ? EVT_OT_CLR : EVT_OT_SET), 5'(codes[k]));
    // standby with both supplies good, transmit held low
    // consumer stalled so the mode change word stays visible
    @(posedge clk);
    evt_ready <= 1'b0;
    put(1, 1, 0, 0, 0);
    step(6);
    chk("mode_stby", 5'(MODE_STANDBY), 5'(mode));
    chk("evt_chg_code", 5'(EVT_MODE), 5'(evt_data.code));
    chk("evt_chg_mode", 5'(MODE_STANDBY), 5'(evt_data.mode));
    chk("drive_stby", 5'h01, 5'(drive));
    put(0, 1, 0, 0, 0);
    step(TMO + 10);
    chk("tmo_stby", 5'h00, 5'(tmo_seen));
    chk("drive_txd_stby", 5'h01, 5'(drive));
    // wake pattern: dominant, recessive, dominant, then one more dominant
    bus(1'b1);
    step(150);
    chk("rxd_wake1", 5'h01, 5'(rxd));
    bus(1'b0);
    step(150);
    bus(1'b1);
    step(130);
    chk("rxd_wake2", 5'h00, 5'(rxd));
    bus(1'b0);
    step(10);
    chk("rxd_wake_rec", 5'h01, 5'(rxd));
    bus(1'b1);
    step(130);
    chk("rxd_wake3", 5'h00, 5'(rxd));
    bus(1'b0);
    step(10);
    // supply faults
    put(1, 1, 0, 1, 0);
    step(6);
    chk("mode_core_stby", 5'(MODE_STANDBY), 5'(mode));
    chk("drive_core_stby", 5'h01, 5'(drive));
    put(1, 0, 0, 1, 0);
    step(6);
    chk("mode_prot", 5'(MODE_PROTECTED), 5'(mode));
    chk("drive_prot", 5'h00, 5'(drive));
    bus(1'b1);
    step(6);
    chk("rxd_prot", 5'h01, 5'(rxd));
    chk("oe_prot", 5'h01, 5'(rxd_oe));
    put(1, 0, 0, 0, 1);
    step(6);
    chk("mode_io", 5'(MODE_IO_LOST), 5'(mode));
    chk("oe_io", 5'h00, 5'(rxd_oe));
    chk("drive_io", 5'h00, 5'(drive));
    bus(1'b0);
    put(1, 0, 0, 0, 0);
    step(10);
    chk("mode_wait", 5'h00, 5'(mode == MODE_NORMAL));
    step(20);
    chk("mode_back", 5'(MODE_NORMAL), 5'(mode));
    put(0, 0, 0, 0, 0);
    step(8);
    chk("rxd_back", 5'h00, 5'(rxd));
    chk("drive_back", 5'h0E, 5'(drive));
    put(1, 0, 0, 0, 0);
    step(4);
    print_verdict();
  end
endmodule
`default_nettype wire
